// ### bench/arl_partner.sv
`timescale 1ns/1ps
// ****************************************
// Reset switches and relay coils
// ****************************************
module arl_partner
    import arl_pkg::*;
(
    input  wire arl_pkg::arl_relay_t relay,
    output logic                     remote_reset,
    output logic                     magnet_reset,
    output logic      [2:0]          coil_on
);
    // Called just after a clock edge, so the switch level changes only there.
    task automatic press(input logic rem, input logic mag);
        remote_reset <= rem;
        magnet_reset <= mag;
    endtask : press
    assign coil_on = relay;
endmodule : arl_partner

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import arl_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [9:0] sig_code = 10'h000;
    logic [3:0] t1_sw = 4'h0, t2_sw = 4'h0, reg_addr = 4'h0;
    logic       sensor_fault = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
    logic       irq, remote_reset, magnet_reset;
    logic [2:0] coil_on;
    arl_relay_t relay;
    int miscompares = 0, cmp_count = 0;
    int h1 = 0, h2 = 0, l1 = 0, l2 = 0, st = 0, mk = 0, lat = 0, fs = 0, fol = 0;
    int s = 0, n1 = 0, n2 = 0, f = 0, man = 0, crr = 0, cmr = 0;
    int offs[5] = '{-1, 0, -12, -13, 0};
    always #2.5 core_clk = ~core_clk;
    arl_relay_logic dut (.core_clk(core_clk), .rst_n(rst_n), .sig_code(sig_code),
        .trip1_sw(t1_sw), .trip2_sw(t2_sw), .sensor_fault(sensor_fault),
        .remote_reset(remote_reset), .magnet_reset(magnet_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .relay(relay));
    arl_partner p (.relay(relay), .remote_reset(remote_reset),
        .magnet_reset(magnet_reset), .coil_on(coil_on));
    // ****************************************
    // Bench model and bus tasks
    // ****************************************
    task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    function automatic int trip(input int sw);
        return int'(ARL_ZERO_CODE) + sw * int'(ARL_SPAN_CODE) / (ARL_SW_STEPS - 1);
    endfunction : trip
    task automatic upd(inout int h, inout int l, input int t);
        int hy;
        hy = int'(ARL_HYST_CODE);
        if (s >= t) begin
            h = 1;
            l = 1;
        end else begin
            if (s < t - hy) h = 0;
            if ((lat == 0 && s < t - hy) || (lat != 0 && man != 0)) l = 0;
        end
    endtask : upd
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (a == ARL_REG_CTRL) begin
            lat = d[ARL_CTRL_LATCH];
            fs = d[ARL_CTRL_FSAFE];
            fol = d[ARL_CTRL_A3A2];
        end
        if (a == ARL_REG_IRQ_ST) st = (st & ~int'(d)) | (f << 3);
        if (a == ARL_REG_IRQ_MK) mk = int'(d) & 15;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic apply(input int ns, input int a, input int b, input int nf,
                         input int rr, input int mr);
        int o1, o2, o3;
        @(posedge core_clk);
        sig_code <= 10'(ns);
        t1_sw <= 4'(a);
        t2_sw <= 4'(b);
        sensor_fault <= 1'(nf);
        p.press(1'(rr), 1'(mr));
        s = ns;
        n1 = a;
        n2 = b;
        f = nf;
        crr = rr;
        cmr = mr;
        man = rr | mr;
        o1 = l1;
        o2 = l2;
        o3 = h2;
        upd(h1, l1, trip(a));
        upd(h2, l2, trip(b));
        st = st | (l1 & ~o1) | ((l2 & ~o2) << 1) | ((h2 & ~o3) << 2) | (f << 3);
        repeat (5) @(posedge core_clk);
        #1;
        check("relay", 10'(coil_on), 10'((l1 ^ fs) * 4 + (l2 ^ fs) * 2
            + (fol != 0 ? h2 ^ fs : 1 - f)));
        check("irq", 10'(irq), 10'((st & mk) != 0));
        rd(ARL_REG_STAT, v);
        check("stat", 10'(v), 10'(f * 32 + h2 * 16 + l2 * 8 + l1 * 4 + h2 * 2 + h1));
        rd(ARL_REG_IRQ_ST, v);
        check("irq_st", 10'(v), 10'(st));
        rd(ARL_REG_SIG, v);
        check("sig", 10'(v), 10'(s >> 2));
    endtask : apply
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h16d8));
        p.press(1'b0, 1'b0);
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(ARL_REG_CTRL, v);
        check("ctrl", 10'(v), 10'(ARL_CTRL_RST));
        rd(ARL_REG_IRQ_MK, v);
        check("mask", 10'(v), 10'(ARL_IRQ_RST));
        rd(4'hf, v);
        check("unmapped", 10'(v), 10'h000);
        wr(ARL_REG_STAT, 8'hff);
        wr(ARL_REG_IRQ_MK, 8'h0f);
        apply(0, 4, 15, 0, 0, 0);
        $display("test reset done");
        for (int k = 0; k < 2; k++) begin
            foreach (offs[i]) apply(trip(k == 0 ? 4 : 15) + offs[i], 4, 15, 0, 0, 0);
        end
        $display("test thresholds done");
        wr(ARL_REG_CTRL, 8'h01);
        apply(s, n1, n2, f, crr, cmr);
        for (int r = 0; r < 2; r++) begin
            apply(600, 4, 15, 0, int'(r == 0), int'(r == 1));
            apply(300, 4, 15, 0, 0, 0);
            apply(300, 4, 15, 0, int'(r == 0), int'(r == 1));
            apply(300, 4, 15, 0, 0, 0);
        end
        $display("test latching done");
        for (int i = 0; i < 64; i++) begin
            wr(ARL_REG_CTRL, 8'(i % 8));
            wr(ARL_REG_IRQ_MK, 8'($urandom));
            wr(ARL_REG_IRQ_ST, 8'($urandom));
            apply(s, n1, n2, f, crr, cmr);
            apply(int'($urandom_range(1023)), int'($urandom_range(15)),
                  int'($urandom_range(15)), int'($urandom_range(1)),
                  int'($urandom_range(3) == 0), int'($urandom_range(3) == 0));
        end
        $display("test random done");
        print_verdict();
    end
endmodule : tb_top

// ### rtl/arl_pkg.sv
package arl_pkg;

    // ************************************************************
    // Measurement scale
    // ************************************************************
    localparam int          ARL_SIG_W      = 10;
    localparam int          ARL_SW_W       = 4;
    // The zero-scale code and the code span for 100 percent of full scale.
    localparam logic [9:0]  ARL_ZERO_CODE  = 10'h0c5;
    localparam logic [9:0]  ARL_SPAN_CODE  = 10'h326;
    // Trip point step per switch position is span divided by 15, one less than the 16 positions.
    localparam int          ARL_SW_STEPS   = 16;
    // About 1.5 percent of the 806-count span.
    localparam logic [9:0]  ARL_HYST_CODE  = 10'h00c;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0]  ARL_REG_CTRL   = 4'h0;
    localparam logic [3:0]  ARL_REG_STAT   = 4'h1;
    localparam logic [3:0]  ARL_REG_IRQ_ST = 4'h2;
    localparam logic [3:0]  ARL_REG_IRQ_MK = 4'h3;
    localparam logic [3:0]  ARL_REG_SIG    = 4'h4;
    localparam logic [7:0]  ARL_CTRL_RST   = 8'h00;
    localparam int          ARL_CTRL_LATCH = 0;
    localparam int          ARL_CTRL_FSAFE = 1;
    localparam int          ARL_CTRL_A3A2  = 2;
    localparam logic [3:0]  ARL_IRQ_RST    = 4'h0;

    typedef struct packed {
        logic       latch_en;
        logic       fail_safe;
        logic       alm3_follow;
    } arl_cfg_t;

    typedef struct packed {
        logic       relay1;
        logic       relay2;
        logic       relay3;
    } arl_relay_t;

endpackage : arl_pkg

// ### rtl/arl_relay_logic.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// How it works
// - Three relay drives are produced, for alarm one, alarm two and a third relay.
// - By default the third relay shows a sensor fault and is driven fail-safe.
// - A configuration bit makes the third relay follow the alarm two trip instead.
// - Each trip point is chosen by a 16-position switch value that the block reads.
// - Without latching, an active alarm clears only once the signal is about 1.5 percent below the trip.
// - With latching chosen, a tripped alarm holds until a manual reset arrives.
// - A remote reset input or a magnetic switch input, either one, clears latched alarms.
// - With fail-safe chosen, the alarm relays are energised without alarm and drop on alarm.
// - The fault relay is always fail-safe, whatever the alarm relay setting.
module arl_relay_logic
    import arl_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic [arl_pkg::ARL_SIG_W-1:0] sig_code,
    input  wire logic [arl_pkg::ARL_SW_W-1:0]  trip1_sw,
    input  wire logic [arl_pkg::ARL_SW_W-1:0]  trip2_sw,
    input  wire logic                    sensor_fault,
    input  wire logic                    remote_reset,
    input  wire logic                    magnet_reset,
    input  wire logic [3:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    output logic                         irq,
    output arl_pkg::arl_relay_t          relay
);
    import arl_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Pins are asynchronous; the first stage feeds only the second.
    localparam int SYN_W = ARL_SIG_W + 2 * ARL_SW_W + 3;
    logic [SYN_W-1:0] syn1_r;
    logic [SYN_W-1:0] syn2_r;
    logic [SYN_W-1:0] syn3_r;
    logic [SYN_W-1:0] coh_r;
    logic [SYN_W-1:0] coh_nxt;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            syn1_r <= '0;
            syn2_r <= '0;
            syn3_r <= '0;
            coh_r  <= '0;
        end else begin
            syn1_r <= {sig_code, trip1_sw, trip2_sw, sensor_fault, remote_reset, magnet_reset};
            syn2_r <= syn1_r;
            syn3_r <= syn2_r;
            coh_r  <= coh_nxt;
        end
    end

    // Bits of one word may cross in different cycles, so a word is taken only once
    // two synchronised samples agree. A pin that changes every cycle is never taken;
    // the measurement, the switches and the reset inputs move far slower than that.
    always_comb begin
        coh_nxt = coh_r;
        if (syn2_r == syn3_r) begin
            coh_nxt = syn2_r;
        end
    end

    logic [ARL_SIG_W-1:0] sig_s;
    logic [ARL_SW_W-1:0]  sw1_s;
    logic [ARL_SW_W-1:0]  sw2_s;
    logic                 fault_s;
    logic                 man_rst;
    assign sig_s   = coh_nxt[SYN_W-1 -: ARL_SIG_W];
    assign sw1_s   = coh_nxt[2*ARL_SW_W+2 -: ARL_SW_W];
    assign sw2_s   = coh_nxt[ARL_SW_W+2 -: ARL_SW_W];
    assign fault_s = coh_nxt[2];
    assign man_rst = coh_nxt[1] | coh_nxt[0];

    // ************************************************************
    // Trip level decode
    // ************************************************************
    // Positions map linearly from zero scale to the top of the span.
    function automatic logic [ARL_SIG_W-1:0] trip_level(input logic [ARL_SW_W-1:0] sw);
        logic [19:0] prod;
        prod = 20'(sw) * 20'(ARL_SPAN_CODE);
        return ARL_ZERO_CODE + ARL_SIG_W'(prod / 20'(ARL_SW_STEPS - 1));
    endfunction : trip_level

    logic [ARL_SIG_W-1:0] trip_lvl [2];
    assign trip_lvl[0] = trip_level(sw1_s);
    assign trip_lvl[1] = trip_level(sw2_s);

    // ************************************************************
    // Registers and alarm state
    // ************************************************************
    logic [7:0]  ctrl_r,   ctrl_nxt;
    logic [1:0]  alm_r,    alm_nxt;
    logic        a3_r,     a3_nxt;
    logic        hys1_r,   hys1_nxt;
    logic [1:0]  hys;
    logic [3:0]  ist_r,    ist_nxt;
    logic [3:0]  imk_r,    imk_nxt;
    logic [7:0]  rdata_r,  rdata_nxt;
    logic        irq_r,    irq_nxt;
    arl_relay_t  relay_r,  relay_nxt;
    arl_cfg_t    cfg;
    logic [1:0]  above;
    logic [1:0]  below;
    logic [1:0]  raw;
    logic [3:0]  ev;

    assign cfg.latch_en    = ctrl_r[ARL_CTRL_LATCH];
    assign cfg.fail_safe   = ctrl_r[ARL_CTRL_FSAFE];
    assign cfg.alm3_follow = ctrl_r[ARL_CTRL_A3A2];
    assign hys             = {a3_r, hys1_r};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cmp
            assign above[g] = sig_s >= trip_lvl[g];
            // Saturate so low trip points never wrap the release level.
            assign below[g] = (trip_lvl[g] < ARL_HYST_CODE) ? 1'b0 :
                              (sig_s < trip_lvl[g] - ARL_HYST_CODE);
            // Hysteretic comparator state, kept apart from the latched alarm.
            assign raw[g] = above[g] | (hys[g] & ~below[g]);
        end
    endgenerate

    always_comb begin
        alm_nxt = alm_r;
        for (int i = 0; i < 2; i++) begin
            if (above[i]) begin
                alm_nxt[i] = 1'b1;
            end else if (cfg.latch_en) begin
                if (man_rst) begin
                    alm_nxt[i] = 1'b0;
                end
            end else if (below[i]) begin
                alm_nxt[i] = 1'b0;
            end
        end
        // The second alarm two relay tracks the trip point only, never latched.
        a3_nxt = above[1] | (a3_r & ~below[1]);
        hys1_nxt = raw[0];
        ev = {fault_s, a3_nxt & ~a3_r, alm_nxt & ~alm_r};

        ctrl_nxt = ctrl_r;
        imk_nxt  = imk_r;
        ist_nxt  = ist_r;
        if (reg_wr && reg_addr == ARL_REG_CTRL) begin
            ctrl_nxt = reg_wdata;
        end
        if (reg_wr && reg_addr == ARL_REG_IRQ_MK) begin
            imk_nxt = reg_wdata[3:0];
        end
        if (reg_wr && reg_addr == ARL_REG_IRQ_ST) begin
            ist_nxt = ist_r & ~reg_wdata[3:0];
        end
        // Set wins over a clear in the same cycle.
        ist_nxt = ist_nxt | ev;
        irq_nxt = |(ist_nxt & imk_nxt);

        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ARL_REG_CTRL:   rdata_nxt = ctrl_r;
                ARL_REG_STAT:   rdata_nxt = {2'h0, fault_s, a3_r, alm_r, raw};
                ARL_REG_IRQ_ST: rdata_nxt = {4'h0, ist_r};
                ARL_REG_IRQ_MK: rdata_nxt = {4'h0, imk_r};
                ARL_REG_SIG:    rdata_nxt = sig_s[ARL_SIG_W-1 -: 8];
                default:        rdata_nxt = 8'h00;
            endcase
        end

        // Relay bit high means coil energised.
        relay_nxt.relay1 = alm_nxt[0] ^ cfg.fail_safe;
        relay_nxt.relay2 = alm_nxt[1] ^ cfg.fail_safe;
        // Fault drive is held energised while healthy, so power loss reads as fault.
        relay_nxt.relay3 = cfg.alm3_follow ? (a3_nxt ^ cfg.fail_safe)
                                           : ~fault_s;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r  <= ARL_CTRL_RST;
            alm_r   <= '0;
            a3_r    <= 1'b0;
            hys1_r  <= 1'b0;
            ist_r   <= ARL_IRQ_RST;
            imk_r   <= ARL_IRQ_RST;
            rdata_r <= 8'h00;
            irq_r   <= 1'b0;
            relay_r <= '0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            alm_r   <= alm_nxt;
            a3_r    <= a3_nxt;
            hys1_r  <= hys1_nxt;
            ist_r   <= ist_nxt;
            imk_r   <= imk_nxt;
            rdata_r <= rdata_nxt;
            irq_r   <= irq_nxt;
            relay_r <= relay_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq       = irq_r;
    assign relay     = relay_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_trip;
        @(posedge core_clk) disable iff (!rst_n) above[0] |=> alm_r[0];
    endproperty
    a_trip: assert property (p_trip) else $error("alarm one missed trip");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
            (alm_r[1] && !below[1] && !man_rst) |=> alm_r[1];
    endproperty
    a_hold: assert property (p_hold) else $error("alarm two dropped in band");

    property p_latch;
        @(posedge core_clk) disable iff (!rst_n)
            (cfg.latch_en && alm_r[0] && !man_rst) |=> alm_r[0];
    endproperty
    a_latch: assert property (p_latch) else $error("latched alarm lost");

    property p_mrst;
        @(posedge core_clk) disable iff (!rst_n)
            (cfg.latch_en && man_rst && !above[0]) |=> !alm_r[0];
    endproperty
    a_mrst: assert property (p_mrst) else $error("manual reset ignored");

    property p_auto;
        @(posedge core_clk) disable iff (!rst_n)
            (!cfg.latch_en && below[1]) |=> !alm_r[1];
    endproperty
    a_auto: assert property (p_auto) else $error("alarm two did not auto clear");

    property p_fsafe;
        @(posedge core_clk) disable iff (!rst_n)
            $past(rst_n) |-> (relay_r.relay1 == (alm_r[0] ^ $past(cfg.fail_safe)));
    endproperty
    a_fsafe: assert property (p_fsafe) else $error("relay one polarity wrong");

    property p_fault;
        @(posedge core_clk) disable iff (!rst_n)
            (!cfg.alm3_follow && fault_s) |=> !relay_r.relay3;
    endproperty
    a_fault: assert property (p_fault) else $error("fault relay not dropped");

    property p_follow;
        @(posedge core_clk) disable iff (!rst_n)
            (cfg.alm3_follow && above[1] && !cfg.fail_safe) |=> relay_r.relay3;
    endproperty
    a_follow: assert property (p_follow) else $error("third relay not following");

    property p_auto1;
        @(posedge core_clk) disable iff (!rst_n)
            (!cfg.latch_en && below[0]) |=> !alm_r[0];
    endproperty
    a_auto1: assert property (p_auto1) else $error("alarm one did not auto clear");

    property p_relay2;
        @(posedge core_clk) disable iff (!rst_n)
            $past(rst_n) |-> (relay_r.relay2 == (alm_r[1] ^ $past(cfg.fail_safe)));
    endproperty
    a_relay2: assert property (p_relay2) else $error("relay two polarity wrong");

    property p_mrst2;
        @(posedge core_clk) disable iff (!rst_n)
            (cfg.latch_en && man_rst && !above[1]) |=> !alm_r[1];
    endproperty
    a_mrst2: assert property (p_mrst2) else $error("manual reset ignored on two");

    property p_a3free;
        @(posedge core_clk) disable iff (!rst_n)
            (cfg.latch_en && below[1]) |=> !a3_r;
    endproperty
    a_a3free: assert property (p_a3free) else $error("third relay state latched");

    property p_healthy;
        @(posedge core_clk) disable iff (!rst_n)
            (!cfg.alm3_follow && !fault_s) |=> relay_r.relay3;
    endproperty
    a_healthy: assert property (p_healthy) else $error("fault relay not energised");

    property p_fault_ev;
        @(posedge core_clk) disable iff (!rst_n)
            fault_s |=> ist_r[3];
    endproperty
    a_fault_ev: assert property (p_fault_ev) else $error("fault event not recorded");

    c_trip:  cover property (@(posedge core_clk) disable iff (!rst_n) $rose(alm_r[0]));
    c_latch: cover property (@(posedge core_clk) disable iff (!rst_n)
                             cfg.latch_en && alm_r[0] && man_rst);
    c_fault: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(relay_r.relay3));
    c_irq:   cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq_r));
    c_follow: cover property (@(posedge core_clk) disable iff (!rst_n)
                              cfg.alm3_follow && $rose(relay_r.relay3));

endmodule : arl_relay_logic
